// *** step_status_ctl.sv ***
`timescale 1ns/1ps
module step_status_ctl
    import step_status_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [step_status_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [step_status_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_ack_o,
    // driver-side status inputs
    input wire logic [step_status_pkg::LOAD_W-1:0] load_i,
    input wire logic stall_i,
    input wire logic stall_halt_i,
    input wire logic motion_start_i,
    input wire logic overtemp_i,
    input wire logic prewarn_i,
    input wire logic short_a_i,
    input wire logic short_b_i,
    input wire logic open_a_i,
    input wire logic open_b_i,
    // step/direction interface
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic enable_i,
    // current control and direction output
    output logic run_current_o,
    output logic standby_o,
    output logic driver_on_o,
    output logic dir_o
);
    import step_status_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [DELAY_W-1:0] standby_delay_r;
    logic [MODE_W-1:0] pulse_mode_r;
    logic stall_stop_r;
    logic [LOAD_W-1:0] load_r;
    logic [7:0] fault_r;
    logic step_d_r;
    logic [STILL_EXP-1:0] still_cnt_r;
    logic still_r;
    logic run_cur_r;
    logic run_current_r;
    logic standby_r;
    logic driver_on_r;
    logic dir_r;
    logic [DATA_W-1:0] rdata_r;
    logic ack_r;
    logic timer_expired;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    wire step_rise_w = step_i && !step_d_r;
    wire sd_active_w = (pulse_mode_r != MODE_NORMAL);
    wire step_acc_w = step_rise_w && sd_active_w;
    wire stall_rd_w = reg_rd_i && hit(reg_addr_i, REG_STALL_STOP);
    wire still_full_w = &still_cnt_r;
    wire auto_mode_w = (pulse_mode_r == MODE_AUTO) ||
                       (pulse_mode_r == MODE_AUTO_GATE);

    logic [DATA_W-1:0] rd_mux_w;
    always_comb begin
        rd_mux_w = '0;
        case (reg_addr_i)
            REG_LOAD_MEASURE: rd_mux_w = DATA_W'(load_r);
            REG_STALL_STOP: rd_mux_w = DATA_W'(stall_stop_r);
            REG_FAULT_STATUS: rd_mux_w = DATA_W'(fault_r);
            REG_STANDBY_DELAY: rd_mux_w = standby_delay_r;
            REG_PULSE_MODE: rd_mux_w = DATA_W'(pulse_mode_r);
            default: rd_mux_w = '0;
        endcase
    end

    // ------------------------------------------------------------
    // current selection per mode
    // ------------------------------------------------------------
    logic run_nxt;
    logic standby_nxt;
    logic drv_nxt;
    always_comb begin
        run_nxt = 1'b1;
        standby_nxt = 1'b0;
        drv_nxt = 1'b1;
        case (pulse_mode_t'(pulse_mode_r))
            MODE_NORMAL: begin
                run_nxt = 1'b1;
            end
            MODE_ENABLE_SEL: begin
                run_nxt = enable_i;
                standby_nxt = !enable_i;
            end
            MODE_AUTO: begin
                run_nxt = run_cur_r;
                standby_nxt = !run_cur_r;
            end
            MODE_ALWAYS_RUN: begin
                run_nxt = 1'b1;
            end
            MODE_AUTO_GATE: begin
                run_nxt = run_cur_r;
                standby_nxt = !run_cur_r;
                drv_nxt = enable_i;
            end
            MODE_RUN_GATE: begin
                run_nxt = 1'b1;
                drv_nxt = enable_i;
            end
            default: begin
                run_nxt = 1'b1;
            end
        endcase
    end

    standby_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .restart_i(step_acc_w),
        .delay_i(standby_delay_r),
        .expired_o(timer_expired)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            standby_delay_r <= STANDBY_DELAY_RST;
            pulse_mode_r <= PULSE_MODE_RST;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, REG_STANDBY_DELAY) && reg_wdata_i != '0) begin
                standby_delay_r <= reg_wdata_i;
            end
            if (hit(reg_addr_i, REG_PULSE_MODE) &&
                reg_wdata_i[MODE_W-1:0] <= MODE_RUN_GATE) begin
                pulse_mode_r <= reg_wdata_i[MODE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // reads
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_r <= '0;
            ack_r <= 1'b0;
        end else begin
            rdata_r <= reg_rd_i ? rd_mux_w : rdata_r;
            ack_r <= reg_rd_i || reg_wr_i;
        end
    end

    // ------------------------------------------------------------
    // stall-stop flag, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            stall_stop_r <= 1'b0;
        end else if (stall_halt_i) begin
            stall_stop_r <= 1'b1;
        end else if (stall_rd_w || motion_start_i) begin
            stall_stop_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status capture and standstill detection
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            load_r <= '0;
            fault_r <= '0;
            step_d_r <= 1'b0;
            still_cnt_r <= '0;
            still_r <= 1'b0;
        end else begin
            load_r <= load_i;
            fault_r[ST_STALL] <= stall_i;
            fault_r[ST_OVERTEMP] <= overtemp_i;
            fault_r[ST_PREWARN] <= prewarn_i;
            fault_r[ST_SHORT_A] <= short_a_i;
            fault_r[ST_SHORT_B] <= short_b_i;
            fault_r[ST_OPEN_A] <= open_a_i;
            fault_r[ST_OPEN_B] <= open_b_i;
            fault_r[ST_STANDSTILL] <= still_r;
            step_d_r <= step_i;
            if (step_rise_w) begin
                still_cnt_r <= '0;
                still_r <= 1'b0;
            end else if (still_full_w) begin
                still_r <= 1'b1;
            end else begin
                still_cnt_r <= still_cnt_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // current outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            run_cur_r <= 1'b0;
            run_current_r <= 1'b0;
            standby_r <= 1'b0;
            driver_on_r <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            if (step_acc_w) begin
                run_cur_r <= 1'b1;
            end else if (timer_expired) begin
                run_cur_r <= 1'b0;
            end
            run_current_r <= run_nxt;
            standby_r <= standby_nxt;
            driver_on_r <= drv_nxt;
            dir_r <= sd_active_w ? dir_i : dir_r;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_ack_o = ack_r;
    assign run_current_o = run_current_r;
    assign standby_o = standby_r;
    assign driver_on_o = driver_on_r;
    assign dir_o = dir_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_stall_set;
        @(posedge sys_clk_i) disable iff (srst_i)
        stall_halt_i |=> stall_stop_r;
    endproperty
    a_stall_set: assert property (p_stall_set)
        else $error("stall stop flag not set");

    property p_stall_clr;
        @(posedge sys_clk_i) disable iff (srst_i)
        (stall_rd_w && !stall_halt_i) |=> !stall_stop_r;
    endproperty
    a_stall_clr: assert property (p_stall_clr)
        else $error("stall stop flag not cleared by read");

    property p_overtemp;
        @(posedge sys_clk_i) disable iff (srst_i)
        overtemp_i |=> fault_r[ST_OVERTEMP];
    endproperty
    a_overtemp: assert property (p_overtemp)
        else $error("overtemp status missing");

    property p_mode3;
        @(posedge sys_clk_i) disable iff (srst_i)
        (pulse_mode_r == MODE_ALWAYS_RUN) |=> run_current_r && !standby_r;
    endproperty
    a_mode3: assert property (p_mode3)
        else $error("mode 3 left run current");

    property p_mode1;
        @(posedge sys_clk_i) disable iff (srst_i)
        (pulse_mode_r == MODE_ENABLE_SEL) |=> run_current_r == $past(enable_i);
    endproperty
    a_mode1: assert property (p_mode1)
        else $error("mode 1 current does not follow enable");

    property p_mode5;
        @(posedge sys_clk_i) disable iff (srst_i)
        (pulse_mode_r == MODE_RUN_GATE) |=> driver_on_r == $past(enable_i);
    endproperty
    a_mode5: assert property (p_mode5)
        else $error("mode 5 driver gating wrong");

    property p_auto_run;
        @(posedge sys_clk_i) disable iff (srst_i)
        (step_acc_w && auto_mode_w) ##1 auto_mode_w |=> run_current_r;
    endproperty
    a_auto_run: assert property (p_auto_run)
        else $error("auto mode did not switch to run current");

    property p_still_clear;
        @(posedge sys_clk_i) disable iff (srst_i)
        step_rise_w |=> ##1 !fault_r[ST_STANDSTILL];
    endproperty
    a_still_clear: assert property (p_still_clear)
        else $error("standstill bit not cleared by step");
endmodule // step_status_ctl

// *** step_status_pkg.sv ***
package step_status_pkg;
    // register indices (byte-addressed parameter numbers)
    localparam logic [7:0] REG_LOAD_MEASURE = 8'hce;
    localparam logic [7:0] REG_STALL_STOP = 8'hcf;
    localparam logic [7:0] REG_FAULT_STATUS = 8'hd0;
    localparam logic [7:0] REG_STANDBY_DELAY = 8'hd6;
    localparam logic [7:0] REG_PULSE_MODE = 8'hfe;

    localparam int LOAD_W = 10;
    localparam int DELAY_W = 16;
    localparam int MODE_W = 3;
    localparam int DATA_W = 16;

    localparam logic [DELAY_W-1:0] STANDBY_DELAY_RST = 16'h00c8;
    localparam logic [MODE_W-1:0] PULSE_MODE_RST = 3'h0;

    // status bit positions
    localparam int ST_STALL = 0;
    localparam int ST_OVERTEMP = 1;
    localparam int ST_PREWARN = 2;
    localparam int ST_SHORT_A = 3;
    localparam int ST_SHORT_B = 4;
    localparam int ST_OPEN_A = 5;
    localparam int ST_OPEN_B = 6;
    localparam int ST_STANDSTILL = 7;

    // standstill window of 2^20 clocks
    localparam int STILL_EXP = 20;

    // power-down tick: 10 ms at 100 MHz
    localparam int TICK_MS = 10;
    localparam int CLK_MHZ = 100;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICK_W = 20;

    typedef enum logic [MODE_W-1:0] {
        MODE_NORMAL = 3'h0,
        MODE_ENABLE_SEL = 3'h1,
        MODE_AUTO = 3'h2,
        MODE_ALWAYS_RUN = 3'h3,
        MODE_AUTO_GATE = 3'h4,
        MODE_RUN_GATE = 3'h5
    } pulse_mode_t;
endpackage

// *** standby_timer.sv ***
`timescale 1ns/1ps
// counts standstill in tick units after the last step pulse
module standby_timer
    import step_status_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic restart_i,
    input wire logic [step_status_pkg::DELAY_W-1:0] delay_i,
    output logic expired_o
);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    logic [TICK_W-1:0] tick_cnt_r;
    logic [DELAY_W-1:0] unit_cnt_r;
    logic expired_r;
    wire tick_w = (tick_cnt_r == TICK_LAST);
    wire reach_w = (unit_cnt_r >= delay_i) && (delay_i != '0);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || restart_i) begin
            tick_cnt_r <= '0;
            unit_cnt_r <= '0;
            expired_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_w ? '0 : tick_cnt_r + 1'b1;
            if (tick_w && !reach_w) begin
                unit_cnt_r <= unit_cnt_r + 1'b1;
            end
            expired_r <= reach_w;
        end
    end

    assign expired_o = expired_r;
endmodule // standby_timer

// *** step_source.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// step pulse source of the external controller
// ----------------------------------------
module step_source (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [3:0] n_i,
    input wire logic [3:0] gap_i,
    output logic step_o,
    output logic busy_o
);
    initial begin
        step_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            if (go_i === 1'b1) begin
                #1 busy_o = 1'b1;
                // high for two clocks so the rising edge is seen
                repeat (n_i) begin
                    step_o = 1'b1;
                    repeat (2) @(posedge sys_clk_i);
                    #1 step_o = 1'b0;
                    repeat (gap_i) @(posedge sys_clk_i);
                    #1;
                end
                busy_o = 1'b0;
            end
        end
    end
endmodule // step_source

// *** tb_stepper_driver_status_current_ctl.sv ***
`timescale 1ns/1ps
module tb_stepper_driver_status_current_ctl;
    import step_status_pkg::*;
    localparam int TICKS = 4;
    localparam int MAX_CYC = 8000;
    logic clk, srst, wr_s, rd_s, ack, halt, mstart, go, busy;
    logic stp, dir, en, run, stby, drv, dir_q;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, q;
    logic [LOAD_W-1:0] load;
    logic [6:0] flt;
    logic [3:0] n_st, gap;
    int n_fail, n_compared, cyc, seed, m, e, i;

    step_status_ctl #(.TICK_CYCLES(TICKS)) step_status_ctl_inst (
        .sys_clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_ack_o(ack), .load_i(load),
        .stall_i(flt[0]), .stall_halt_i(halt), .motion_start_i(mstart),
        .overtemp_i(flt[1]), .prewarn_i(flt[2]), .short_a_i(flt[3]),
        .short_b_i(flt[4]), .open_a_i(flt[5]), .open_b_i(flt[6]),
        .step_i(stp), .dir_i(dir), .enable_i(en), .run_current_o(run),
        .standby_o(stby), .driver_on_o(drv), .dir_o(dir_q));

    step_source step_source_inst (.sys_clk_i(clk), .go_i(go),
        .n_i(n_st), .gap_i(gap), .step_o(stp), .busy_o(busy));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic stop_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t reg %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t cur %b exp %b m=%0d", $time, got, exp, m);
        end
    endtask

    // {run, standby, driver on}
    function automatic logic [2:0] exp_cur(input int md, input logic ena,
        input logic idle);
        case (md)
            1: return {ena, !ena, 1'b1};
            2: return {!idle, idle, 1'b1};
            4: return {!idle, idle, ena};
            5: return {2'b10, ena};
            default: return 3'b101;
        endcase
    endfunction

    // ----------------------------------------
    // register port and step tasks
    // ----------------------------------------
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        addr = a;
        wdata = d;
        wr_s = w;
        rd_s = !w;
        @(posedge clk);
        #1 wr_s = 1'b0;
        rd_s = 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            $display("ERROR t=%0t no acknowledge", $time);
        end
        q = rdata;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        cmp16(q, exp);
    endtask

    task automatic steps(input logic [3:0] n, input logic [3:0] g);
        n_st = n;
        gap = g;
        go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        @(posedge clk);
        #1 i = 0;
        while (busy === 1'b1 && i < 400) begin
            @(posedge clk);
            #1 i++;
        end
    endtask

    task automatic pulse_halt(input logic h, input logic s);
        halt = h;
        mstart = s;
        @(posedge clk);
        #1 halt = 1'b0;
        mstart = 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc >= MAX_CYC) begin
            n_fail++;
            stop_test();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 72172;
        {srst, wr_s, rd_s, halt, mstart, go, dir, en} = 8'h81;
        {addr, wdata, load, flt, n_st, gap} = '0;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        rd(REG_STANDBY_DELAY, 16'h00c8);
        rd(REG_PULSE_MODE, 16'h0000);
        cmp3({run, stby, drv}, 3'b101);
        dir = 1'b1;
        en = 1'b0;
        steps(4'h2, 4'h3);
        cmp3({run, stby, drv}, 3'b101);
        cmp16({15'h0, dir_q}, 16'h0000);
        for (i = 0; i < 6; i++) begin
            load = (i == 0) ? 10'h3ff : 10'($random(seed));
            @(posedge clk);
            #1 rd(REG_LOAD_MEASURE, {6'h00, load});
        end
        for (e = 0; e < 12; e++) begin
            flt = (e < 7) ? 7'(1 << e) : 7'($random(seed));
            @(posedge clk);
            #1 rd(REG_FAULT_STATUS, {9'h000, flt});
        end
        flt = '0;
        pulse_halt(1'b1, 1'b0);
        rd(REG_STALL_STOP, 16'h0001);
        rd(REG_STALL_STOP, 16'h0000);
        pulse_halt(1'b1, 1'b0);
        pulse_halt(1'b0, 1'b1);
        rd(REG_STALL_STOP, 16'h0000);
        acc(1'b1, REG_FAULT_STATUS, 16'h00ff);
        rd(REG_FAULT_STATUS, 16'h0000);
        rd(8'h00, 16'h0000);
        acc(1'b1, REG_STANDBY_DELAY, 16'h0000);
        rd(REG_STANDBY_DELAY, 16'h00c8);
        acc(1'b1, REG_STANDBY_DELAY, 16'h0004);
        rd(REG_STANDBY_DELAY, 16'h0004);
        for (m = 1; m <= 5; m++) begin
            acc(1'b1, REG_PULSE_MODE, 16'(m));
            rd(REG_PULSE_MODE, 16'(m));
            for (e = 0; e < 2; e++) begin
                en = e[0];
                dir = 1'($random(seed));
                // spacing below the delay, train longer than it
                steps(4'h4, 4'h6);
                @(posedge clk);
                #1 cmp3({run, stby, drv}, exp_cur(m, en, 1'b0));
                cmp16({15'h0, dir_q}, {15'h0, dir});
                repeat (4 * TICKS + 20) @(posedge clk);
                #1 cmp3({run, stby, drv}, exp_cur(m, en, 1'b1));
                cmp16({15'h0, q}, {15'h0, q});
            end
        end
        acc(1'b1, REG_PULSE_MODE, 16'h0006);
        rd(REG_PULSE_MODE, 16'h0005);
        rd(REG_FAULT_STATUS, 16'h0000);
        stop_test();
    end
endmodule // tb_stepper_driver_status_current_ctl
